/* File: verilog/ohpw_regs.sv */
// posted-write error registers, identifier and host controller control pair
`timescale 1ns/1ps
`include "ohpw_consts.svh"
// Functional notes
// R01: failed write logs bus and node numbers
// R02: upper offset bits into low half
// R03: error word changes only on failure
// R04: lower offset word captured at 38h
// R05: fixed read-only identifier at 40h
// R06: set at 50h, clear at 54h
// R07: valid flag enables rom reads, updates
// R08: flag clear answers ack_type_error
// R09: bus reset without flag keeps registers
// R10: software sets flag only link disabled
// R11: software builds image before setting flag
// R12: flag cleared only by resets, fetch error
// R13: error registers ignore software writes
module ohpw_regs (
   input wire logic clock,
   input wire logic rstn,
   input wire ohpw_pkg::ohpw_addr_t addr,
   input wire ohpw_pkg::ohpw_word_t wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output ohpw_pkg::ohpw_word_t rd_data_q,
   input wire logic pw_fail,
   input wire logic [15:0] pw_requester_node_ident,
   input wire logic [15:0] pw_failed_offset_upper,
   input wire logic [31:0] pw_failed_offset_lower,
   input wire logic bus_reset,
   input wire logic fetch_error,
   input wire logic soft_reset,
   input wire logic rom_rd_req,
   input wire logic rom_update_req,
   output logic rom_rd_grant_q,
   output logic rom_rd_type_err_q,
   output logic rom_update_grant_q,
   output logic bus_info_image_valid_q,
   output logic link_active_enable_q,
   output ohpw_pkg::ohpw_word_t rom_map_base_q,
   output ohpw_pkg::ohpw_word_t rom_hdr_q,
   output ohpw_pkg::ohpw_word_t bus_opt_q,
   output logic irq_q
);

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic ohpw_hit(input ohpw_pkg::ohpw_addr_t a,
                                     input ohpw_pkg::ohpw_addr_t ofs);
      return a == ofs;
   endfunction

   function automatic ohpw_pkg::ohpw_word_t ohpw_ev_word(input ohpw_pkg::ohpw_ev_t e);
      return {{(32-`OHPW_EV_W){1'b0}}, e};
   endfunction

   logic wr_set;
   logic wr_clr;
   logic wr_map;
   logic wr_hdr;
   logic wr_opt;
   logic wr_stat;
   logic wr_mask;
   logic set_valid_req;
   logic set_valid_ok;
   logic flag_drop;

   assign wr_set = wr_stb && ohpw_hit(addr, `OHPW_OFS_CTL_SET);
   assign wr_clr = wr_stb && ohpw_hit(addr, `OHPW_OFS_CTL_CLR);
   assign wr_map = wr_stb && ohpw_hit(addr, `OHPW_OFS_ROM_MAP);
   assign wr_hdr = wr_stb && ohpw_hit(addr, `OHPW_OFS_ROM_HDR);
   assign wr_opt = wr_stb && ohpw_hit(addr, `OHPW_OFS_BUS_OPT);
   assign wr_stat = wr_stb && ohpw_hit(addr, `OHPW_OFS_IRQ_STAT);
   assign wr_mask = wr_stb && ohpw_hit(addr, `OHPW_OFS_IRQ_MASK);
   assign set_valid_req = wr_set && wr_data[`OHPW_CTL_VALID_BIT];
   // R10: set refused while link enabled
   assign set_valid_ok = set_valid_req && !link_active_enable_q;
   assign flag_drop = fetch_error || soft_reset;

   // ----------------------------------------
   // error log
   // ----------------------------------------
   ohpw_log_if log_bus ();

   // R01: requester ident into upper bits
   // R02: upper destination offset into low half
   assign log_bus.cap = pw_fail;
   assign log_bus.cap_upper = {pw_requester_node_ident, pw_failed_offset_upper};
   // R04: lower offset word
   assign log_bus.cap_lower = pw_failed_offset_lower;

   ohpw_err_log u_log (
      .clock(clock),
      .rstn(rstn),
      .log(log_bus.store)
   );

   // ----------------------------------------
   // host controller control flags
   // ----------------------------------------
   // R12: only resets or fetch error clear it
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bus_info_image_valid_q <= 1'b0;
      end else if (flag_drop) begin
         bus_info_image_valid_q <= 1'b0;
      end else if (set_valid_ok) begin
         bus_info_image_valid_q <= 1'b1;
      end
   end

   // R06: set and clear pair for link enable
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         link_active_enable_q <= 1'b0;
      end else if (soft_reset) begin
         link_active_enable_q <= 1'b0;
      end else if (wr_set && wr_data[`OHPW_CTL_LINK_BIT]) begin
         link_active_enable_q <= 1'b1;
      end else if (wr_clr && wr_data[`OHPW_CTL_LINK_BIT]) begin
         link_active_enable_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // configuration rom responses
   // ----------------------------------------
   // R07: grant while flag set
   // R08: refuse with type error while clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rom_rd_grant_q <= 1'b0;
         rom_rd_type_err_q <= 1'b0;
         rom_update_grant_q <= 1'b0;
      end else begin
         rom_rd_grant_q <= rom_rd_req && bus_info_image_valid_q;
         rom_rd_type_err_q <= rom_rd_req && !bus_info_image_valid_q;
         rom_update_grant_q <= rom_update_req && bus_info_image_valid_q;
      end
   end

   // ----------------------------------------
   // rom image registers: pending and active
   // ----------------------------------------
   ohpw_pkg::ohpw_word_t map_pend_q;
   ohpw_pkg::ohpw_word_t hdr_pend_q;
   ohpw_pkg::ohpw_word_t opt_pend_q;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         map_pend_q <= `OHPW_ZERO;
         hdr_pend_q <= `OHPW_ZERO;
         opt_pend_q <= `OHPW_ZERO;
      end else begin
         if (wr_map) begin
            map_pend_q <= wr_data & `OHPW_MAP_MASK;
         end
         if (wr_hdr) begin
            hdr_pend_q <= wr_data;
         end
         if (wr_opt) begin
            opt_pend_q <= wr_data;
         end
      end
   end

   // R09: bus reset loads only with flag set
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rom_map_base_q <= `OHPW_ZERO;
         rom_hdr_q <= `OHPW_ZERO;
         bus_opt_q <= `OHPW_ZERO;
      end else if (bus_reset && bus_info_image_valid_q) begin
         rom_map_base_q <= map_pend_q;
         rom_hdr_q <= hdr_pend_q;
         bus_opt_q <= opt_pend_q;
      end
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   ohpw_pkg::ohpw_ev_t stat_q;
   ohpw_pkg::ohpw_ev_t mask_q;
   ohpw_pkg::ohpw_ev_t ev;
   ohpw_pkg::ohpw_ev_t stat_clr;

   always_comb begin
      ev = `OHPW_EV_ZERO;
      ev[`OHPW_EV_PW_FAIL] = pw_fail;
      ev[`OHPW_EV_ROM_REFUSED] = rom_rd_req && !bus_info_image_valid_q;
      ev[`OHPW_EV_FETCH_ERR] = fetch_error && bus_info_image_valid_q;
      stat_clr = wr_stat ? wr_data[`OHPW_EV_W-1:0] : `OHPW_EV_ZERO;
   end

   // new events win over a same-cycle clear
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         stat_q <= `OHPW_EV_ZERO;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | ev;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mask_q <= `OHPW_EV_ZERO;
      end else if (wr_mask) begin
         mask_q <= wr_data[`OHPW_EV_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   ohpw_pkg::ohpw_word_t rd_mux;
   ohpw_pkg::ohpw_word_t ctl_word;

   always_comb begin
      ctl_word = `OHPW_ZERO;
      ctl_word[`OHPW_CTL_VALID_BIT] = bus_info_image_valid_q;
      ctl_word[`OHPW_CTL_LINK_BIT] = link_active_enable_q;
   end

   always_comb begin
      rd_mux = `OHPW_ZERO;
      case (addr)
         `OHPW_OFS_ROM_HDR: rd_mux = rom_hdr_q;
         `OHPW_OFS_BUS_OPT: rd_mux = bus_opt_q;
         `OHPW_OFS_ROM_MAP: rd_mux = rom_map_base_q;
         // R13: error words read-only
         `OHPW_OFS_PW_LO: rd_mux = log_bus.lower;
         `OHPW_OFS_PW_HI: rd_mux = log_bus.upper;
         // R05: fixed identifier
         `OHPW_OFS_ORG_ID: rd_mux = `OHPW_ORG_ID_VAL;
         // R06: both addresses read flags
         `OHPW_OFS_CTL_SET: rd_mux = ctl_word;
         `OHPW_OFS_CTL_CLR: rd_mux = ctl_word;
         `OHPW_OFS_IRQ_STAT: rd_mux = ohpw_ev_word(stat_q);
         `OHPW_OFS_IRQ_MASK: rd_mux = ohpw_ev_word(mask_q);
         default: rd_mux = `OHPW_ZERO;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_data_q <= `OHPW_ZERO;
      end else if (rd_stb) begin
         rd_data_q <= rd_mux;
      end else begin
         rd_data_q <= `OHPW_ZERO;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_fail_read_hi;
      pw_fail ##1 (rd_stb && addr == `OHPW_OFS_PW_HI && !pw_fail);
   endsequence

   chk_ident_logged: assert property (@(posedge clock) disable iff (!rstn) // R01
      pw_fail |=> log_bus.upper[31:16] == $past(pw_requester_node_ident))
      else $error("requester ident not logged");
   chk_offset_hi_read: assert property (@(posedge clock) disable iff (!rstn) // R02
      s_fail_read_hi |=> rd_data_q[15:0] == $past(pw_failed_offset_upper, 2))
      else $error("upper offset not readable after failure");
   chk_offset_lo_logged: assert property (@(posedge clock) disable iff (!rstn) // R04
      pw_fail |=> log_bus.lower == $past(pw_failed_offset_lower))
      else $error("lower offset not logged");
   chk_ident_fixed: assert property (@(posedge clock) disable iff (!rstn) // R05
      rd_stb && addr == `OHPW_OFS_ORG_ID |=> rd_data_q == `OHPW_ORG_ID_VAL)
      else $error("identifier read wrong");
   chk_link_clear: assert property (@(posedge clock) disable iff (!rstn) // R06
      wr_clr && wr_data[`OHPW_CTL_LINK_BIT] |=> !link_active_enable_q)
      else $error("clear write left link enable set");
   chk_flag_read: assert property (@(posedge clock) disable iff (!rstn) // R06
      rd_stb && addr == `OHPW_OFS_CTL_CLR
      |=> rd_data_q[`OHPW_CTL_VALID_BIT] == $past(bus_info_image_valid_q))
      else $error("flag read disagrees");
   chk_rom_grant: assert property (@(posedge clock) disable iff (!rstn) // R07
      rom_rd_req && bus_info_image_valid_q |=> rom_rd_grant_q && !rom_rd_type_err_q)
      else $error("rom read not granted");
   chk_rom_refuse: assert property (@(posedge clock) disable iff (!rstn) // R08
      rom_rd_req && !bus_info_image_valid_q |=> rom_rd_type_err_q && !rom_rd_grant_q)
      else $error("rom read not refused");
   chk_map_kept: assert property (@(posedge clock) disable iff (!rstn) // R09
      bus_reset && !bus_info_image_valid_q
      |=> $stable(rom_map_base_q) && $stable(rom_hdr_q) && $stable(bus_opt_q))
      else $error("rom registers changed on reset without flag");
   chk_set_gated: assert property (@(posedge clock) disable iff (!rstn) // R10
      set_valid_req && link_active_enable_q && !bus_info_image_valid_q
      |=> !bus_info_image_valid_q)
      else $error("flag set while link enabled");
   chk_flag_sticky: assert property (@(posedge clock) disable iff (!rstn) // R12
      bus_info_image_valid_q && !flag_drop |=> bus_info_image_valid_q)
      else $error("flag dropped without cause");
   chk_flag_drop: assert property (@(posedge clock) disable iff (!rstn) // R12
      flag_drop |=> !bus_info_image_valid_q)
      else $error("flag survived fetch error or soft reset");

   // ----------------------------------------
   // checks: rom image, control, interrupts and read path
   // ----------------------------------------
   sequence s_reset_with_image;
      bus_reset && bus_info_image_valid_q;
   endsequence

   chk_image_loaded: assert property (@(posedge clock) disable iff (!rstn) // R07
      s_reset_with_image |=> rom_map_base_q == $past(map_pend_q)
      && rom_hdr_q == $past(hdr_pend_q) && bus_opt_q == $past(opt_pend_q))
      else $error("rom image not loaded on bus reset");
   chk_update_grant: assert property (@(posedge clock) disable iff (!rstn) // R07
      rom_update_req && bus_info_image_valid_q |=> rom_update_grant_q)
      else $error("rom update not granted");
   chk_update_refuse: assert property (@(posedge clock) disable iff (!rstn) // R07
      rom_update_req && !bus_info_image_valid_q |=> !rom_update_grant_q)
      else $error("rom update granted without flag");
   chk_set_taken: assert property (@(posedge clock) disable iff (!rstn) // R06
      set_valid_req && !link_active_enable_q && !flag_drop |=> bus_info_image_valid_q)
      else $error("flag set write lost");
   chk_link_soft: assert property (@(posedge clock) disable iff (!rstn)
      soft_reset |=> !link_active_enable_q)
      else $error("link enable survived soft reset");
   chk_stat_set_wins: assert property (@(posedge clock) disable iff (!rstn)
      pw_fail |=> stat_q[`OHPW_EV_PW_FAIL])
      else $error("failure event not recorded");
   chk_stat_w1c: assert property (@(posedge clock) disable iff (!rstn)
      wr_stat && wr_data[`OHPW_EV_PW_FAIL] && !pw_fail |=> !stat_q[`OHPW_EV_PW_FAIL])
      else $error("status bit not cleared by write");
   chk_irq_on: assert property (@(posedge clock) disable iff (!rstn)
      |(stat_q & mask_q) |=> irq_q)
      else $error("interrupt not raised");
   chk_irq_off: assert property (@(posedge clock) disable iff (!rstn)
      !(|(stat_q & mask_q)) |=> !irq_q)
      else $error("interrupt raised without cause");
   chk_rd_idle: assert property (@(posedge clock) disable iff (!rstn)
      !rd_stb |=> rd_data_q == `OHPW_ZERO)
      else $error("read data outside read cycle");
endmodule

/* File: verilog/ohpw_consts.svh */
// address map, field positions and fixed values of the error/control register slice
`ifndef OHPW_CONSTS_SVH
`define OHPW_CONSTS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OHPW_ADDR_W 8
`define OHPW_OFS_ROM_HDR 8'h18
`define OHPW_OFS_BUS_OPT 8'h20
`define OHPW_OFS_ROM_MAP 8'h34
`define OHPW_OFS_PW_LO 8'h38
`define OHPW_OFS_PW_HI 8'h3c
`define OHPW_OFS_ORG_ID 8'h40
`define OHPW_OFS_CTL_SET 8'h50
`define OHPW_OFS_CTL_CLR 8'h54
`define OHPW_OFS_IRQ_STAT 8'h60
`define OHPW_OFS_IRQ_MASK 8'h64

// ----------------------------------------
// fields and values
// ----------------------------------------
// arbitrary identifier value
`define OHPW_ORG_ID_VAL 32'h00a5_5a00
`define OHPW_CTL_VALID_BIT 31
`define OHPW_CTL_LINK_BIT 17
`define OHPW_MAP_MASK 32'hffff_fc00
`define OHPW_ZERO 32'h0000_0000
`define OHPW_EV_W 3
`define OHPW_EV_PW_FAIL 0
`define OHPW_EV_ROM_REFUSED 1
`define OHPW_EV_FETCH_ERR 2
`define OHPW_EV_ZERO 3'h0

`endif

/* File: verilog/ohpw_pkg.sv */
// types shared by the error/control register slice
`include "ohpw_consts.svh"
package ohpw_pkg;
   typedef logic [31:0] ohpw_word_t;
   typedef logic [`OHPW_EV_W-1:0] ohpw_ev_t;
   typedef logic [`OHPW_ADDR_W-1:0] ohpw_addr_t;
endpackage

/* File: verilog/ohpw_log_if.sv */
// carrier between the register slice and its posted-write error log
`timescale 1ns/1ps
interface ohpw_log_if;
   logic cap;
   ohpw_pkg::ohpw_word_t cap_upper;
   ohpw_pkg::ohpw_word_t cap_lower;
   ohpw_pkg::ohpw_word_t upper;
   ohpw_pkg::ohpw_word_t lower;
   modport ctrl (output cap, output cap_upper, output cap_lower, input upper, input lower);
   modport store (input cap, input cap_upper, input cap_lower, output upper, output lower);
endinterface

/* File: verilog/ohpw_err_log.sv */
// posted-write error log: upper and lower error words, hardware capture only
`timescale 1ns/1ps
`include "ohpw_consts.svh"
module ohpw_err_log (
   input wire logic clock,
   input wire logic rstn,
   ohpw_log_if.store log
);
   ohpw_pkg::ohpw_word_t upper_q;
   ohpw_pkg::ohpw_word_t lower_q;

   // ----------------------------------------
   // capture
   // ----------------------------------------
   // R03: update only on failure
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         upper_q <= `OHPW_ZERO;
      end else if (log.cap) begin
         upper_q <= log.cap_upper;
      end
   end

   // R04: lower offset capture
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lower_q <= `OHPW_ZERO;
      end else if (log.cap) begin
         lower_q <= log.cap_lower;
      end
   end

   assign log.upper = upper_q;
   assign log.lower = lower_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_log_hold_idle: assert property (@(posedge clock) disable iff (!rstn) // R13
      !log.cap |=> $stable(upper_q) && $stable(lower_q))
      else $error("error log changed without a capture");
   chk_log_takes_word: assert property (@(posedge clock) disable iff (!rstn) // R03
      log.cap |=> upper_q == $past(log.cap_upper))
      else $error("upper error word not captured");
endmodule

/* File: testbench/ohci_posted_write_error_and_hc_ctrl_test.sv */
// self-checking bench for the posted-write error and host control register slice
`timescale 1ns/1ps
`include "ohpw_consts.svh"
module ohci_posted_write_error_and_hc_ctrl_test;
   localparam int EV_PW = 0;
   localparam int EV_BR = 1;
   localparam int EV_FE = 2;
   localparam int EV_SR = 3;
   localparam int EV_RD = 4;
   localparam int EV_UP = 5;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   ohpw_pkg::ohpw_addr_t addr = 8'h00;
   ohpw_pkg::ohpw_word_t wr_data = 32'h0000_0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [5:0] ev = 6'h00;
   logic [15:0] ident = 16'h0000;
   logic [15:0] ofs_hi = 16'h0000;
   logic [31:0] ofs_lo = 32'h0000_0000;
   ohpw_pkg::ohpw_word_t rd_data_q, map_q, hdr_q, opt_q, val, rnd, last_hi;
   logic grant_q, type_err_q, upd_q, valid_q, link_q, irq_q;
   integer error_cnt = 0;
   integer checked = 0;
   integer seed = 32'ha909a3cc;
   integer i;

   ohpw_regs uut (.clock(clock), .rstn(rstn), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q), .pw_fail(ev[EV_PW]),
      .pw_requester_node_ident(ident), .pw_failed_offset_upper(ofs_hi),
      .pw_failed_offset_lower(ofs_lo), .bus_reset(ev[EV_BR]), .fetch_error(ev[EV_FE]),
      .soft_reset(ev[EV_SR]), .rom_rd_req(ev[EV_RD]), .rom_update_req(ev[EV_UP]),
      .rom_rd_grant_q(grant_q), .rom_rd_type_err_q(type_err_q),
      .rom_update_grant_q(upd_q), .bus_info_image_valid_q(valid_q),
      .link_active_enable_q(link_q), .rom_map_base_q(map_q), .rom_hdr_q(hdr_q),
      .bus_opt_q(opt_q), .irq_q(irq_q));

   always #50 clock = ~clock;

   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   function automatic ohpw_pkg::ohpw_word_t ctl_exp(input logic f, input logic l);
      return {f, 13'h0000, l, 17'h00000};
   endfunction

   task automatic end_of_test;
      if (error_cnt == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic cmp_w(input ohpw_pkg::ohpw_word_t got, input ohpw_pkg::ohpw_word_t exp,
                        input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_b(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic wr(input ohpw_pkg::ohpw_addr_t a, input ohpw_pkg::ohpw_word_t d);
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input ohpw_pkg::ohpw_addr_t a, input ohpw_pkg::ohpw_word_t exp,
                     input string what);
      @(posedge clock);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      @(negedge clock);
      cmp_w(rd_data_q, exp, what);
   endtask

   // one-cycle event pulse, returns where its answer stands
   task automatic pulse(input int k);
      @(posedge clock);
      ev <= 6'h01 << k;
      @(posedge clock);
      ev <= 6'h00;
      @(negedge clock);
   endtask

   // failure pulse followed at once by a read of the upper error word
   task automatic fail_rd(input ohpw_pkg::ohpw_word_t exp);
      @(posedge clock);
      ev <= 6'h01 << EV_PW;
      @(posedge clock);
      ev <= 6'h00;
      addr <= `OHPW_OFS_PW_HI;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      @(negedge clock);
      cmp_w(rd_data_q, exp, "err hi next");
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      end_of_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      rd(`OHPW_OFS_ORG_ID, `OHPW_ORG_ID_VAL, "id");
      @(negedge clock);
      cmp_w(rd_data_q, `OHPW_ZERO, "rd hold");
      rd(`OHPW_OFS_CTL_CLR, `OHPW_ZERO, "ctl rst");
      wr(`OHPW_OFS_ORG_ID, 32'hffff_ffff);
      rd(`OHPW_OFS_ORG_ID, `OHPW_ORG_ID_VAL, "id wr");
      wr(8'h7c, 32'hffff_ffff);
      rd(8'h7c, `OHPW_ZERO, "unmapped");
      wr(`OHPW_OFS_IRQ_MASK, 32'h0000_0002);
      for (i = 0; i < 10; i++) begin
         rnd = $random(seed);
         val = $random(seed);
         @(posedge clock);
         ident <= (i == 0) ? 16'hffc0 : (i == 1) ? 16'h003f : rnd[15:0];
         ofs_hi <= rnd[31:16];
         ofs_lo <= val;
         pulse(EV_PW);
         last_hi = {ident, ofs_hi};
         wr(`OHPW_OFS_PW_HI, ~last_hi);
         wr(`OHPW_OFS_PW_LO, ~ofs_lo);
         rd(`OHPW_OFS_PW_HI, last_hi, "err hi");
         rd(`OHPW_OFS_PW_LO, ofs_lo, "err lo");
      end
      rnd = $random(seed);
      @(posedge clock);
      ident <= rnd[15:0];
      ofs_hi <= rnd[31:16];
      last_hi = {rnd[15:0], rnd[31:16]};
      fail_rd(last_hi);
      rd(`OHPW_OFS_IRQ_STAT, 32'h0000_0001, "stat pw");
      rd(`OHPW_OFS_IRQ_MASK, 32'h0000_0002, "mask rd");
      cmp_b(irq_q, 1'b0, "irq masked");
      // failure event and its clear in one cycle: the event wins
      @(posedge clock);
      addr <= `OHPW_OFS_IRQ_STAT;
      wr_data <= 32'h0000_0001;
      wr_stb <= 1'b1;
      ev <= 6'h01 << EV_PW;
      @(posedge clock);
      wr_stb <= 1'b0;
      ev <= 6'h00;
      rd(`OHPW_OFS_IRQ_STAT, 32'h0000_0001, "stat win");
      wr(`OHPW_OFS_IRQ_STAT, 32'h0000_0001);
      rd(`OHPW_OFS_IRQ_STAT, `OHPW_ZERO, "stat w1c");
      // flag clear: refusals and frozen rom image
      pulse(EV_RD);
      cmp_b(type_err_q, 1'b1, "type err");
      cmp_b(grant_q, 1'b0, "no grant");
      @(negedge clock);
      cmp_b(irq_q, 1'b1, "irq set");
      pulse(EV_UP);
      cmp_b(upd_q, 1'b0, "no upd");
      wr(`OHPW_OFS_IRQ_STAT, 32'h0000_0002);
      repeat (2) @(negedge clock);
      cmp_b(irq_q, 1'b0, "irq clr");
      val = $random(seed);
      wr(`OHPW_OFS_ROM_MAP, val);
      wr(`OHPW_OFS_ROM_HDR, ~val);
      wr(`OHPW_OFS_BUS_OPT, val ^ 32'h5a5a_5a5a);
      pulse(EV_BR);
      @(negedge clock);
      rd(`OHPW_OFS_ROM_MAP, `OHPW_ZERO, "map frz");
      rd(`OHPW_OFS_ROM_HDR, `OHPW_ZERO, "hdr frz");
      rd(`OHPW_OFS_BUS_OPT, `OHPW_ZERO, "opt frz");
      rd(`OHPW_OFS_PW_HI, last_hi, "err keep");
      // set/clear pair and link interlock
      wr(`OHPW_OFS_CTL_SET, 32'h0002_0000);
      rd(`OHPW_OFS_CTL_CLR, ctl_exp(1'b0, 1'b1), "link set");
      wr(`OHPW_OFS_CTL_SET, 32'h8000_0000);
      rd(`OHPW_OFS_CTL_SET, ctl_exp(1'b0, 1'b1), "flag blk");
      wr(`OHPW_OFS_CTL_CLR, 32'h0002_0000);
      wr(`OHPW_OFS_CTL_SET, 32'h8000_0000);
      rd(`OHPW_OFS_CTL_CLR, ctl_exp(1'b1, 1'b0), "flag set");
      cmp_b(valid_q, 1'b1, "flag pin");
      pulse(EV_RD);
      cmp_b(grant_q, 1'b1, "grant");
      cmp_b(type_err_q, 1'b0, "no err");
      pulse(EV_UP);
      cmp_b(upd_q, 1'b1, "upd");
      pulse(EV_BR);
      @(negedge clock);
      cmp_w(map_q, val & `OHPW_MAP_MASK, "map upd");
      cmp_w(hdr_q, ~val, "hdr upd");
      cmp_w(opt_q, val ^ 32'h5a5a_5a5a, "opt upd");
      rd(`OHPW_OFS_ROM_MAP, val & `OHPW_MAP_MASK, "map rd");
      // flag stays until reset or fetch error
      wr(`OHPW_OFS_CTL_CLR, 32'hffff_ffff);
      rd(`OHPW_OFS_CTL_SET, ctl_exp(1'b1, 1'b0), "no sw clr");
      pulse(EV_FE);
      cmp_b(valid_q, 1'b0, "fetch clr");
      rd(`OHPW_OFS_IRQ_STAT, 32'h0000_0004, "stat fe");
      wr(`OHPW_OFS_CTL_SET, 32'h8000_0000);
      wr(`OHPW_OFS_CTL_SET, 32'h0002_0000);
      pulse(EV_SR);
      cmp_b(valid_q, 1'b0, "soft clr");
      cmp_b(link_q, 1'b0, "soft link");
      wr(`OHPW_OFS_CTL_SET, 32'h8000_0000);
      @(negedge clock);
      cmp_b(valid_q, 1'b1, "flag again");
      @(posedge clock);
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      cmp_b(valid_q, 1'b0, "hw clr");
      rd(`OHPW_OFS_PW_HI, `OHPW_ZERO, "err rst");
      end_of_test();
   end
endmodule
